// File: src/can_rate_decode.sv
`timescale 1ns/1ps
module can_rate_decode
  import fsw_cfg_pkg::*;
(
  // Selector
  input wire logic [3:0] code_i,
  // Result
  output logic [9:0] kbaud_o,
  output logic valid_o
);

  always_comb
  begin
    valid_o = 1'b1;
    case (code_i)
      4'h1: kbaud_o = KBAUD_50;
      4'h2: kbaud_o = KBAUD_100;
      4'h3: kbaud_o = KBAUD_125;
      4'h4: kbaud_o = KBAUD_250;
      4'h5: kbaud_o = KBAUD_500;
      4'h6: kbaud_o = KBAUD_800;
      4'h7: kbaud_o = KBAUD_1000;
      default:
      begin
        kbaud_o = 10'h000;
        valid_o = 1'b0;
      end
    endcase
  end

endmodule // can_rate_decode

// File: src/fieldbus_switch_config_decoder.sv
// Summary of operation
// - On the CAN variant the 7-bit node address is bank one positions 2..4 over bank two 1..4.
// - On the CAN variant the rate selector codes 1..7 give 50/100/125/250/500/800/1000 kBaud.
// - The factory selector position gives a CAN rate of 125 kBaud.
// - With a CAN or Profibus option fitted, RS485 settings come from commissioning config.
// - Without such an option the RS485 address is bank one position 4 over bank two 1..4.
// - The RS485 selector gives 7E1/7N1/8E1/8N1 at 9600/19200/38400, codes 3/7/B/F unused.
// - The CAN link takes commands from the master and answers with operating and process state.
// - The RS485 link answers only at its configured node address.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module fieldbus_switch_config_decoder
  import fsw_cfg_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Switches and option straps
  input wire logic [7:0] SWITCH_BANK_ONE_I,
  input wire logic [3:0] SWITCH_BANK_TWO_I,
  input wire logic [3:0] ROTARY_RATE_SELECTOR_I,
  input wire logic CAN_FITTED_I,
  input wire logic PBUS_FITTED_I,
  // CAN link side
  input wire logic CAN_CMD_VLD_I,
  input wire logic [6:0] CAN_CMD_NODE_I,
  input wire logic [31:0] CAN_CMD_DATA_I,
  output logic CAN_ACK_VLD_O,
  output logic [15:0] CAN_ACK_STATE_O,
  output logic [6:0] CAN_NODE_ADDR_O,
  output logic [9:0] CAN_KBAUD_O,
  output logic CAN_CFG_VALID_O,
  // RS485 link side
  input wire logic RS_RX_VLD_I,
  input wire logic [4:0] RS_RX_ADDR_I,
  output logic RS_ADDR_HIT_O,
  output logic [4:0] RS_NODE_ADDR_O,
  output logic [15:0] RS_BAUD_O,
  output logic RS_DATA8_O,
  output logic RS_PARITY_O,
  output logic RS_CFG_VALID_O,
  // Status
  output logic CFG_LOADED_O
);

  boot_state_t state_q;
  logic [7:0] one_q;
  logic [3:0] two_q;
  logic [3:0] sel_q;
  logic can_fit_q;
  logic option_q;
  logic rsvd_err;
  logic [31:0] rs_comm_q;
  logic [31:0] drv_state_q;
  logic [31:0] can_cmd_q;
  logic [9:0] can_kbaud;
  logic can_rate_ok;
  logic [15:0] sw_baud;
  logic sw_data8;
  logic sw_parity;
  logic sw_ok;
  logic [15:0] cm_baud;
  logic cm_data8;
  logic cm_parity;
  logic cm_ok;
  logic apb_setup;
  logic apb_wr;
  logic [31:0] rd_data;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequence and one-time switch capture
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state_q <= ST_SAMPLE;
    else
    begin
      case (state_q)
        ST_SAMPLE: state_q <= ST_DECODE;
        ST_DECODE: state_q <= ST_RUN;
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_SAMPLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      one_q <= 8'h00;
      two_q <= 4'h0;
      sel_q <= 4'h0;
      can_fit_q <= 1'b0;
      option_q <= 1'b0;
    end
    else if (state_q == ST_SAMPLE)
    begin
      one_q <= SWITCH_BANK_ONE_I;
      two_q <= SWITCH_BANK_TWO_I;
      sel_q <= ROTARY_RATE_SELECTOR_I;
      can_fit_q <= CAN_FITTED_I;
      option_q <= CAN_FITTED_I | PBUS_FITTED_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoders
  can_rate_decode u_can_rate (
    .code_i(sel_q),
    .kbaud_o(can_kbaud),
    .valid_o(can_rate_ok)
  );

  rs485_fmt_decode u_rs_sw (
    .code_i(sel_q),
    .baud_o(sw_baud),
    .data8_o(sw_data8),
    .parity_o(sw_parity),
    .valid_o(sw_ok)
  );

  rs485_fmt_decode u_rs_comm (
    .code_i(rs_comm_q[RS_COMM_SEL_POS +: 4]),
    .baud_o(cm_baud),
    .data8_o(cm_data8),
    .parity_o(cm_parity),
    .valid_o(cm_ok)
  );

  // Reserved switch found ON
  assign rsvd_err = can_fit_q ? |(one_q & CAN_RSVD_MASK) :
    (!option_q && |(one_q & RS_RSVD_MASK));

  ////////////////////////////////////////////////////////////////////////////
  // CAN settings
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      CAN_NODE_ADDR_O <= CAN_FACTORY_ADDR;
      CAN_KBAUD_O <= KBAUD_125;
      CAN_CFG_VALID_O <= 1'b0;
    end
    else if (state_q == ST_DECODE)
    begin
      CAN_NODE_ADDR_O <= {one_q[1], one_q[2], one_q[3],
        two_q[0], two_q[1], two_q[2], two_q[3]};
      CAN_KBAUD_O <= can_kbaud;
      CAN_CFG_VALID_O <= can_fit_q && can_rate_ok && !rsvd_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RS485 settings
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      RS_NODE_ADDR_O <= RS_FACTORY_ADDR;
      RS_BAUD_O <= BAUD_9600;
      RS_DATA8_O <= 1'b0;
      RS_PARITY_O <= 1'b1;
      RS_CFG_VALID_O <= 1'b0;
    end
    else if (state_q != ST_SAMPLE && option_q)
    begin
      RS_NODE_ADDR_O <= rs_comm_q[4:0];
      RS_BAUD_O <= cm_baud;
      RS_DATA8_O <= cm_data8;
      RS_PARITY_O <= cm_parity;
      RS_CFG_VALID_O <= cm_ok;
    end
    else if (state_q == ST_DECODE)
    begin
      RS_NODE_ADDR_O <= {one_q[3], two_q[0], two_q[1], two_q[2], two_q[3]};
      RS_BAUD_O <= sw_baud;
      RS_DATA8_O <= sw_data8;
      RS_PARITY_O <= sw_parity;
      RS_CFG_VALID_O <= sw_ok && !rsvd_err;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      CFG_LOADED_O <= 1'b0;
    else
      CFG_LOADED_O <= (state_q != ST_SAMPLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link slave behaviour
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      CAN_ACK_VLD_O <= 1'b0;
      CAN_ACK_STATE_O <= 16'h0000;
      can_cmd_q <= 32'h0000_0000;
    end
    else
    begin
      CAN_ACK_VLD_O <= 1'b0;
      if (CAN_CMD_VLD_I && CFG_LOADED_O && CAN_CFG_VALID_O &&
          CAN_CMD_NODE_I == CAN_NODE_ADDR_O)
      begin
        can_cmd_q <= CAN_CMD_DATA_I;
        CAN_ACK_VLD_O <= 1'b1;
        CAN_ACK_STATE_O <= drv_state_q[15:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      RS_ADDR_HIT_O <= 1'b0;
    else
      RS_ADDR_HIT_O <= RS_RX_VLD_I && CFG_LOADED_O && RS_CFG_VALID_O &&
        RS_RX_ADDR_I == RS_NODE_ADDR_O;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR_I)
      OFS_STATUS:
      begin
        rd_data[STAT_LOADED_POS] = CFG_LOADED_O;
        rd_data[STAT_CAN_VALID_POS] = CAN_CFG_VALID_O;
        rd_data[STAT_RS_VALID_POS] = RS_CFG_VALID_O;
        rd_data[STAT_RSVD_ERR_POS] = rsvd_err;
        rd_data[STAT_OPTION_POS] = option_q;
        rd_data[STAT_CAN_FIT_POS] = can_fit_q;
      end
      OFS_CAN_CFG:
      begin
        rd_data[6:0] = CAN_NODE_ADDR_O;
        rd_data[CAN_CFG_KBAUD_POS +: 10] = CAN_KBAUD_O;
      end
      OFS_RS_CFG:
      begin
        rd_data[4:0] = RS_NODE_ADDR_O;
        rd_data[RS_CFG_BAUD_POS +: 16] = RS_BAUD_O;
        rd_data[RS_CFG_DATA8_POS] = RS_DATA8_O;
        rd_data[RS_CFG_PARITY_POS] = RS_PARITY_O;
      end
      OFS_RS_COMM: rd_data = rs_comm_q;
      OFS_DRV_STATE: rd_data = drv_state_q;
      OFS_CAN_CMD: rd_data = can_cmd_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= apb_setup;
      PRDATA_O <= (apb_setup && !PWRITE_I) ? rd_data : 32'h0000_0000;
      PSLVERR_O <= apb_setup && !rd_hit;
    end
  end

  // Writable registers, byte lanes honoured
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rs_comm_q <= RS_COMM_RESET;
      drv_state_q <= DRV_STATE_RESET;
    end
    else if (apb_wr)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (PSTRB_I[b] && PADDR_I == OFS_RS_COMM)
          rs_comm_q[b*8 +: 8] <= PWDATA_I[b*8 +: 8];
        if (PSTRB_I[b] && PADDR_I == OFS_DRV_STATE)
          drv_state_q[b*8 +: 8] <= PWDATA_I[b*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence boot_s;
    state_q == ST_SAMPLE ##1 state_q == ST_DECODE ##1 CFG_LOADED_O;
  endsequence

  boot_latch_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    CFG_LOADED_O && $past(CFG_LOADED_O) |-> $stable(one_q) && $stable(sel_q))
    else $error("switch capture changed after load");

  boot_seq_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    state_q == ST_SAMPLE |-> boot_s)
    else $error("boot sequence broken");

  can_addr_map_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    state_q == ST_DECODE |=> CAN_NODE_ADDR_O ==
      {one_q[1], one_q[2], one_q[3], two_q[0], two_q[1], two_q[2], two_q[3]})
    else $error("CAN address mapping wrong");

  can_rate_max_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    CFG_LOADED_O && sel_q == 4'h7 |-> CAN_KBAUD_O == KBAUD_1000)
    else $error("CAN code 7 not 1000 kBaud");

  can_rate_dflt_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    CFG_LOADED_O && sel_q == CAN_FACTORY_CODE |-> CAN_KBAUD_O == KBAUD_125)
    else $error("factory CAN rate not 125 kBaud");

  rs_comm_src_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    CFG_LOADED_O && option_q |=> RS_NODE_ADDR_O == $past(rs_comm_q[4:0]))
    else $error("RS485 address not from commissioning config");

  rs_sw_addr_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    CFG_LOADED_O && !option_q |->
      RS_NODE_ADDR_O == {one_q[3], two_q[0], two_q[1], two_q[2], two_q[3]})
    else $error("RS485 switch address wrong");

  rs_fmt_dec_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    CFG_LOADED_O && !option_q && sel_q == 4'hC |->
      RS_BAUD_O == BAUD_9600 && RS_DATA8_O && !RS_PARITY_O)
    else $error("RS485 code C not 8N1 9600");

  can_ack_state_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    CAN_ACK_VLD_O |-> CAN_ACK_STATE_O == $past(drv_state_q[15:0]) &&
      $past(CAN_CMD_NODE_I) == CAN_NODE_ADDR_O)
    else $error("CAN acknowledge wrong");

  rs_addr_hit_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    RS_RX_VLD_I && RS_RX_ADDR_I != RS_NODE_ADDR_O |=> !RS_ADDR_HIT_O)
    else $error("RS485 answered foreign address");

endmodule // fieldbus_switch_config_decoder

// File: src/fsw_cfg_pkg.sv
package fsw_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_CAN_CFG = 12'h004;
  localparam logic [11:0] OFS_RS_CFG = 12'h008;
  localparam logic [11:0] OFS_RS_COMM = 12'h00C;
  localparam logic [11:0] OFS_DRV_STATE = 12'h010;
  localparam logic [11:0] OFS_CAN_CMD = 12'h014;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int STAT_LOADED_POS = 0;
  localparam int STAT_CAN_VALID_POS = 1;
  localparam int STAT_RS_VALID_POS = 2;
  localparam int STAT_RSVD_ERR_POS = 3;
  localparam int STAT_OPTION_POS = 4;
  localparam int STAT_CAN_FIT_POS = 5;
  localparam int CAN_CFG_KBAUD_POS = 8;
  localparam int RS_CFG_BAUD_POS = 8;
  localparam int RS_CFG_DATA8_POS = 24;
  localparam int RS_CFG_PARITY_POS = 25;
  localparam int RS_COMM_SEL_POS = 8;
  localparam int DRV_PROC_POS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and factory values
  localparam logic [31:0] RS_COMM_RESET = 32'h0000_0001;
  localparam logic [31:0] DRV_STATE_RESET = 32'h0000_0000;
  localparam logic [6:0] CAN_FACTORY_ADDR = 7'h7F;
  localparam logic [3:0] CAN_FACTORY_CODE = 4'h3;
  localparam logic [4:0] RS_FACTORY_ADDR = 5'h01;
  localparam logic [3:0] RS_FACTORY_CODE = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Reserved switch masks of bank one (bit n is position n+1)
  localparam logic [7:0] CAN_RSVD_MASK = 8'hF1;
  localparam logic [7:0] RS_RSVD_MASK = 8'hF7;

  ////////////////////////////////////////////////////////////////////////////
  // Rates
  localparam logic [9:0] KBAUD_50 = 10'h032;
  localparam logic [9:0] KBAUD_100 = 10'h064;
  localparam logic [9:0] KBAUD_125 = 10'h07D;
  localparam logic [9:0] KBAUD_250 = 10'h0FA;
  localparam logic [9:0] KBAUD_500 = 10'h1F4;
  localparam logic [9:0] KBAUD_800 = 10'h320;
  localparam logic [9:0] KBAUD_1000 = 10'h3E8;
  localparam logic [15:0] BAUD_9600 = 16'h2580;
  localparam logic [15:0] BAUD_19200 = 16'h4B00;
  localparam logic [15:0] BAUD_38400 = 16'h9600;

  typedef enum logic [1:0] {ST_SAMPLE, ST_DECODE, ST_RUN} boot_state_t;

endpackage

// File: src/rs485_fmt_decode.sv
`timescale 1ns/1ps
module rs485_fmt_decode
  import fsw_cfg_pkg::*;
(
  // Selector
  input wire logic [3:0] code_i,
  // Result
  output logic [15:0] baud_o,
  output logic data8_o,
  output logic parity_o,
  output logic valid_o
);

  // Upper bits pick the format, lower two the rate
  always_comb
  begin
    data8_o = code_i[3];
    parity_o = ~code_i[2];
    valid_o = 1'b1;
    case (code_i[1:0])
      2'b00: baud_o = BAUD_9600;
      2'b01: baud_o = BAUD_19200;
      2'b10: baud_o = BAUD_38400;
      default:
      begin
        baud_o = 16'h0000;
        valid_o = 1'b0;
      end
    endcase
  end

endmodule // rs485_fmt_decode

// File: verif/fieldbus_master_model.sv
`timescale 1ns/1ps
module fieldbus_master_model
(
  // Clock
  input wire logic clk_i,
  // CAN master side
  output logic cmd_vld_o,
  output logic [6:0] cmd_node_o,
  output logic [31:0] cmd_data_o,
  // RS485 master side
  output logic rx_vld_o,
  output logic [4:0] rx_addr_o
);
  initial
  begin
    cmd_vld_o = 1'b0;
    cmd_node_o = 7'h00;
    cmd_data_o = 32'h0000_0000;
    rx_vld_o = 1'b0;
    rx_addr_o = 5'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command to a node, held one cycle; released lines invert
  task automatic can_send(input logic [6:0] n, input logic [31:0] d, input bit last);
    cmd_vld_o <= 1'b1;
    cmd_node_o <= n;
    cmd_data_o <= d;
    @(posedge clk_i);
    if (last)
    begin
      cmd_vld_o <= 1'b0;
      cmd_node_o <= ~n;
      cmd_data_o <= ~d;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Frame address to the network
  task automatic rs_send(input logic [4:0] a, input bit last);
    rx_vld_o <= 1'b1;
    rx_addr_o <= a;
    @(posedge clk_i);
    if (last)
    begin
      rx_vld_o <= 1'b0;
      rx_addr_o <= ~a;
    end
  endtask
endmodule // fieldbus_master_model

// File: verif/fieldbus_switch_config_decoder_test.sv
`timescale 1ns/1ps
module fieldbus_switch_config_decoder_test
  import fsw_cfg_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pd = 32'h0000_0000;
  logic [7:0] b1 = 8'h00;
  logic [3:0] b2 = 4'h0, rot = 4'h0;
  logic [3:0] pstrb = 4'hF;
  logic canf = 1'b0, pbf = 1'b0, rx_q = 1'b0;
  logic cmd_vld, rx_vld, ack_vld, can_ok, hit, d8, par, rs_ok, loaded, pready, pslverr;
  logic [6:0] cmd_node, can_addr;
  logic [31:0] cmd_data, prdata;
  logic [4:0] rx_addr, rs_addr;
  logic [15:0] ack_st, rs_baud;
  logic [9:0] kbaud;
  logic [32:0] qa [$];
  logic [15:0] qc [$];
  logic qr [$];
  int mismatches = 0;
  int n_compared = 0;

  always #2.5 clk = ~clk;

  fieldbus_switch_config_decoder fieldbus_switch_config_decoder_inst (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw),
    .PADDR_I(pa), .PWDATA_I(pd), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SWITCH_BANK_ONE_I(b1), .SWITCH_BANK_TWO_I(b2),
    .ROTARY_RATE_SELECTOR_I(rot), .CAN_FITTED_I(canf), .PBUS_FITTED_I(pbf),
    .CAN_CMD_VLD_I(cmd_vld), .CAN_CMD_NODE_I(cmd_node), .CAN_CMD_DATA_I(cmd_data),
    .CAN_ACK_VLD_O(ack_vld), .CAN_ACK_STATE_O(ack_st), .CAN_NODE_ADDR_O(can_addr),
    .CAN_KBAUD_O(kbaud), .CAN_CFG_VALID_O(can_ok), .RS_RX_VLD_I(rx_vld),
    .RS_RX_ADDR_I(rx_addr), .RS_ADDR_HIT_O(hit), .RS_NODE_ADDR_O(rs_addr),
    .RS_BAUD_O(rs_baud), .RS_DATA8_O(d8), .RS_PARITY_O(par), .RS_CFG_VALID_O(rs_ok),
    .CFG_LOADED_O(loaded));

  fieldbus_master_model fieldbus_master_model_inst (
    .clk_i(clk), .cmd_vld_o(cmd_vld), .cmd_node_o(cmd_node), .cmd_data_o(cmd_data),
    .rx_vld_o(rx_vld), .rx_addr_o(rx_addr));

  ////////////////////////////////////////////////////////////////////////////
  // Checking and reporting
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [10:0] can_exp(input logic [3:0] c);
    case (c)
      4'h1: return {1'b1, KBAUD_50};
      4'h2: return {1'b1, KBAUD_100};
      4'h3: return {1'b1, KBAUD_125};
      4'h4: return {1'b1, KBAUD_250};
      4'h5: return {1'b1, KBAUD_500};
      4'h6: return {1'b1, KBAUD_800};
      4'h7: return {1'b1, KBAUD_1000};
      default: return 11'h000;
    endcase
  endfunction

  function automatic logic [18:0] rs_exp(input logic [3:0] c);
    logic [15:0] b;
    b = (c[1:0] == 2'h0) ? BAUD_9600 : (c[1:0] == 2'h1) ? BAUD_19200 : BAUD_38400;
    if (c[1:0] == 2'h3)
      return 19'h0_0000;
    return {1'b1, c[3], ~c[2], b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus and boot drivers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pw <= w;
    pa <= a;
    pd <= d;
    if (!w)
      qa.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(33'h0_0000_0000, 33'h0_0000_0001);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic boot(input logic [7:0] a, input logic [3:0] b, input logic [3:0] c,
                      input logic cf, input logic pf);
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    b1 <= a;
    b2 <= b;
    rot <= c;
    canf <= cf;
    pbf <= pf;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (loaded !== 1'b1 && n < 20);
    if (n >= 20)
      chk(33'h0_0000_0000, 33'h0_0000_0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(posedge clk)
  begin
    if (psel && pen && !pw && pready === 1'b1 && qa.size() > 0)
      chk({pslverr, prdata}, qa.pop_front());
    if (ack_vld === 1'b1)
      chk(33'(ack_st), (qc.size() > 0) ? 33'(qc.pop_front()) : 33'h1_FFFF_FFFF);
    if (rx_q)
      chk(33'(hit), 33'(qr.pop_front()));
    rx_q <= (rx_vld === 1'b1);
  end

  initial
  begin
    #100000;
    mismatches++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial
  begin
    logic [31:0] seed;
    logic [7:0] a;
    logic [3:0] b, c;
    logic [10:0] e;
    logic [18:0] f;
    logic rsv;
    seed = 32'h87bd_93c1;
    for (int i = 0; i < 32; i++)
    begin
      seed = lfsr(seed);
      rsv = (i % 5 == 4);
      c = i[3:0];
      b = seed[3:0];
      e = can_exp(c);
      f = rs_exp(c);
      a = (i < 16) ? {4'h0, seed[6:4], rsv} : {4'h0, seed[4], 2'h0, rsv};
      boot(a, b, c, i < 16, 1'b0);
      if (i < 16)
      begin
        chk(33'(can_addr), 33'({a[1], a[2], a[3], b[0], b[1], b[2], b[3]}));
        chk(33'(kbaud), 33'(e[9:0]));
        chk(33'(can_ok), 33'(e[10] & ~rsv));
      end
      else
      begin
        chk(33'({rs_ok, rs_addr, rs_baud}),
            33'({f[18] & ~rsv, a[3], b[0], b[1], b[2], b[3], f[15:0]}));
        if (f[18])
          chk(33'({d8, par}), 33'(f[17:16]));
      end
    end
    $display("test switch decode done");
    boot(8'h0E, 4'hF, 4'h3, 1'b1, 1'b0);
    b1 <= seed[7:0];
    b2 <= seed[11:8];
    rot <= seed[15:12];
    repeat (3) @(posedge clk);
    chk(33'({can_addr, kbaud, can_ok}), 33'({7'h7F, KBAUD_125, 1'b1}));
    $display("test latch done");
    apb(1'b0, OFS_STATUS, 32'h0000_0000, 33'h0_0000_0037);
    apb(1'b1, OFS_CAN_CFG, 32'hFFFF_FFFF, 33'h0_0000_0000);
    apb(1'b0, OFS_CAN_CFG, 32'h0000_0000, 33'h0_0000_7D7F);
    apb(1'b0, OFS_RS_COMM, 32'h0000_0000, 33'(RS_COMM_RESET));
    apb(1'b0, OFS_DRV_STATE, 32'h0000_0000, 33'(DRV_STATE_RESET));
    apb(1'b0, 12'h020, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, OFS_DRV_STATE, 32'h0000_A55A, 33'h0_0000_0000);
    $display("test registers done");
    chk(33'({rs_ok, rs_addr, rs_baud, d8, par}), 33'({1'b1, 5'h01, BAUD_9600, 2'h1}));
    qr.push_back(1'b1);
    fieldbus_master_model_inst.rs_send(5'h01, 1'b1);
    repeat (3) @(posedge clk);
    qr.push_back(1'b0);
    fieldbus_master_model_inst.rs_send(5'h05, 1'b1);
    apb(1'b1, OFS_RS_COMM, 32'h0000_0905, 33'h0_0000_0000);
    repeat (2) @(posedge clk);
    chk(33'({rs_ok, rs_addr, rs_baud, d8, par}), 33'({1'b1, 5'h05, BAUD_19200, 2'h3}));
    qr.push_back(1'b1);
    qr.push_back(1'b0);
    fieldbus_master_model_inst.rs_send(5'h05, 1'b0);
    fieldbus_master_model_inst.rs_send(5'h01, 1'b1);
    apb(1'b0, OFS_RS_CFG, 32'h0000_0000, 33'h0_034B_0005);
    $display("test rs485 done");
    seed = lfsr(seed);
    qc.push_back(16'hA55A);
    qc.push_back(16'hA55A);
    fieldbus_master_model_inst.can_send(7'h7F, ~seed, 1'b0);
    fieldbus_master_model_inst.can_send(7'h7F, seed, 1'b0);
    fieldbus_master_model_inst.can_send(7'h03, 32'h0000_1234, 1'b1);
    repeat (3) @(posedge clk);
    apb(1'b0, OFS_CAN_CMD, 32'h0000_0000, 33'(seed));
    pstrb <= 4'h1;
    apb(1'b1, OFS_DRV_STATE, 32'hFFFF_0011, 33'h0_0000_0000);
    pstrb <= 4'hF;
    apb(1'b0, OFS_DRV_STATE, 32'h0000_0000, 33'h0_0000_A511);
    $display("test can done");
    boot(8'h0E, 4'hF, 4'h3, 1'b0, 1'b1);
    chk(33'({can_ok, rs_addr, rs_baud}), 33'({1'b0, 5'h01, BAUD_9600}));
    repeat (3) @(posedge clk);
    chk(33'(qa.size() + qc.size() + qr.size()), 33'h0_0000_0000);
    $display("test option done");
    final_report();
  end
endmodule // fieldbus_switch_config_decoder_test
